// ### logic/sirq_pkg.sv
// Shared constants and state types for the serial interrupt link ends
package sirq_pkg;
  // Frame layout
  localparam int SIRQ_NUM_FRAMES = 16; // Frames that carry request levels
  localparam int SIRQ_HOST_FRAMES = 17; // Frames the host clocks per cycle
  localparam logic [4:0] SIRQ_FRAME_FIRST = 5'h01; // Frame counter start value
  localparam logic [4:0] SIRQ_FRAME_LAST = 5'h10; // Last level frame
  localparam logic [4:0] SIRQ_FRAME_END = 5'h12; // Frame count whose turnaround phase starts the host's stop pulse
  localparam logic [4:0] SIRQ_FRAME_SAT = 5'h1F; // Counter saturation value
  localparam int SIRQ_SMI_FRAME = 3; // Frame shared by management request and irq 2
  localparam int SIRQ_IRQ13_FRAME = 14; // Frame carrying irq 13
  // Phase positions inside a three clock frame
  localparam logic [1:0] SIRQ_PH_REC = 2'h0; // Recovery phase
  localparam logic [1:0] SIRQ_PH_TURN = 2'h1; // Turnaround phase
  localparam logic [1:0] SIRQ_PH_SAMPLE = 2'h2; // Sample phase
  // Pulse widths in clocks
  localparam logic [1:0] SIRQ_STOP_QUIET = 2'h2; // Stop low width selecting quiet mode
  localparam logic [1:0] SIRQ_STOP_CONT = 2'h3; // Stop low width selecting continuous mode
  localparam logic [2:0] SIRQ_EXT_MIN = 3'h3; // Least host extension of a start pulse
  localparam logic [3:0] SIRQ_CNT_ONE = 4'h1; // First clock of a counted pulse

  // Device end states
  typedef enum logic [1:0] {
    SIRQ_DS_IDLE,
    SIRQ_DS_START,
    SIRQ_DS_FRAMES
  } sirq_dev_state_e;

  // Host end states
  typedef enum logic [2:0] {
    SIRQ_HS_IDLE,
    SIRQ_HS_START,
    SIRQ_HS_RISE,
    SIRQ_HS_RUN,
    SIRQ_HS_STOP,
    SIRQ_HS_STOP_HI
  } sirq_host_state_e;
endpackage

// ### logic/sirq_link_if.sv
// Serial interrupt wire shared by the device end and the host end
`timescale 1ns/100ps
interface sirq_link_if;
  logic dev_oe; // Device drives the wire
  logic dev_out; // Device drive value
  logic host_oe; // Host drives the wire
  logic host_out; // Host drive value
  logic serial_interrupt_line; // Resolved wire level, pulled high when undriven

  // Pull-up wire: any driver pushing low wins
  assign serial_interrupt_line = !((dev_oe && !dev_out) || (host_oe && !host_out));

  modport dev (output dev_oe, output dev_out, input serial_interrupt_line);
  modport host (output host_oe, output host_out, input serial_interrupt_line);
endinterface

// ### logic/sirq_dev.sv
// Slave agent end of the serial interrupt link
// Summary of operation
// - Start pulse low time is four to eight clocks
// - Quiet start: one low clock, then release
// - Start only while line is idle
// - Host extends slave start, then drives high
// - Level change in quiet mode triggers start
// - Continuous mode: only host starts cycles
// - Stop low two clocks quiet, three continuous
// - Mode taken from measured stop width only
// - Reset selects continuous mode
// - Frames counted from start rising edge, three clocks
// - Sample phase drives low for low level
// - Recovery drives high after own low
// - Turnaround always releases the line
// - Levels presented whoever started the cycle
// - Frame n sampled 3n-1 clocks after edge
// - Frame map: unused, irq1, shared, irq3-15
// - Frame three carries management request or irq2
// - Frame fourteen carries irq 13
// - Next start comes no sooner than one idle clock after stop turnaround
// - Host may run cycles back to back
// - Quiet start no earlier than second clock after stop
// - Drive and sample on rising clock edge
// - Line released during reset
`timescale 1ns/100ps
module sirq_dev
  import sirq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link side
  sirq_link_if.dev link,
  // Request levels
  input wire logic [15:1] irq_level_in,
  input wire logic system_mgmt_request_n,
  input wire logic mgmt_request_enable_mask,
  // Status
  output logic quiet_mode,
  output logic cycle_active
);

  // Builds frame levels from request levels
  function automatic logic [16:1] frame_map(input logic [15:1] irq, input logic smi_n,
                                            input logic smi_en);
    logic [16:1] f;
    f = 16'hFFFF;
    f[2] = irq[1];
    f[SIRQ_SMI_FRAME] = irq[2] & (smi_n | ~smi_en);
    for (int k = 4; k <= SIRQ_NUM_FRAMES; k++) begin
      f[k] = irq[k - 1];
    end
    return f;
  endfunction

  // Picks one frame's level, high outside the map
  function automatic logic frame_bit(input logic [16:1] v, input logic [4:0] idx);
    logic b;
    b = 1'b1;
    for (int k = 1; k <= SIRQ_NUM_FRAMES; k++) begin
      if (idx == 5'(k)) begin
        b = v[k];
      end
    end
    return b;
  endfunction

  // Synchroniser stages
  logic [15:1] irq_meta_reg; // First stage, read only by second
  logic [15:1] irq_sync_reg; // Second stage
  logic smi_meta_reg; // First stage, read only by second
  logic smi_sync_reg; // Second stage
  // Level tracking
  logic [16:1] frame_now; // Current frame levels
  logic [16:1] det_reg; // Last detected frame levels
  logic [16:1] pend_reg; // Changes not yet delivered
  logic [16:1] deliver; // Frame whose level is being committed
  // Cycle tracking
  sirq_dev_state_e state_reg; // Cycle state
  logic line; // Wire level
  logic line_prev_reg; // Wire level one clock earlier
  logic rise; // Wire rising edge
  logic [1:0] phase_reg; // Position within frame
  logic [4:0] frame_reg; // Upcoming frame index
  logic [1:0] low_cnt_reg; // Stop pulse low width
  logic holdoff_reg; // Idle long enough to start
  logic quiet_reg; // Mode of next cycle
  logic start_go; // Begin own start pulse
  // Drive registers
  logic oe_reg; // Drive enable
  logic out_reg; // Drive value
  logic drove_reg; // Drove low in last sample phase
  logic active_reg; // Cycle under way

  assign line = link.serial_interrupt_line;
  assign rise = line & ~line_prev_reg;
  assign frame_now = frame_map(irq_sync_reg, smi_sync_reg, mgmt_request_enable_mask);
  // Own start only in quiet mode, on an idle line, after the hold-off
  assign start_go = (state_reg == SIRQ_DS_IDLE) && line && quiet_reg && holdoff_reg
                    && (|pend_reg);

  // Two stage synchronisers for request pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_meta_reg <= '1;
      irq_sync_reg <= '1;
      smi_meta_reg <= 1'b1;
      smi_sync_reg <= 1'b1;
    end else begin
      irq_meta_reg <= irq_level_in;
      irq_sync_reg <= irq_meta_reg;
      smi_meta_reg <= system_mgmt_request_n;
      smi_sync_reg <= smi_meta_reg;
    end
  end

  // Held detected levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      det_reg <= '1;
    end else begin
      det_reg <= frame_now;
    end
  end

  // Frame committed at the clock before its sample phase
  always_comb begin
    deliver = '0;
    if (state_reg == SIRQ_DS_FRAMES && phase_reg == SIRQ_PH_TURN) begin
      for (int k = 1; k <= SIRQ_NUM_FRAMES; k++) begin
        deliver[k] = (frame_reg == 5'(k));
      end
    end
  end

  // Pending changes, a new change wins over delivery
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~deliver) | (frame_now ^ det_reg);
    end
  end

  // Wire history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_prev_reg <= 1'b1;
    end else begin
      line_prev_reg <= line;
    end
  end

  // Cycle state, frame counting and stop measurement
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= SIRQ_DS_IDLE;
      phase_reg <= SIRQ_PH_REC;
      frame_reg <= SIRQ_FRAME_FIRST;
      low_cnt_reg <= 2'h0;
      holdoff_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SIRQ_DS_IDLE: begin
          holdoff_reg <= 1'b1;
          // Any start pulse, own or foreign, opens a cycle
          if (!line || start_go) begin
            state_reg <= SIRQ_DS_START;
          end
        end
        SIRQ_DS_START: begin
          // Frames counted from the start pulse rising edge
          if (rise) begin
            state_reg <= SIRQ_DS_FRAMES;
            phase_reg <= SIRQ_PH_TURN;
            frame_reg <= SIRQ_FRAME_FIRST;
            low_cnt_reg <= 2'h0;
          end
        end
        SIRQ_DS_FRAMES: begin
          // Three clock frames: sample, recovery, turnaround
          if (phase_reg == SIRQ_PH_SAMPLE) begin
            phase_reg <= SIRQ_PH_REC;
            if (frame_reg != SIRQ_FRAME_SAT) begin
              frame_reg <= frame_reg + 5'h01;
            end
          end else begin
            phase_reg <= phase_reg + 2'h1;
          end
          // Stop pulse watched once all level frames passed
          if (frame_reg > SIRQ_FRAME_LAST) begin
            if (!line) begin
              if (low_cnt_reg != SIRQ_STOP_CONT) begin
                low_cnt_reg <= low_cnt_reg + 2'h1;
              end
            end else if (low_cnt_reg >= SIRQ_STOP_QUIET) begin
              quiet_reg <= (low_cnt_reg == SIRQ_STOP_QUIET);
              state_reg <= SIRQ_DS_IDLE;
              holdoff_reg <= 1'b0;
            end else begin
              low_cnt_reg <= 2'h0; // Single low clock is a sample, not a stop
            end
          end
        end
      endcase
    end
  end

  // Wire drive, decided one clock ahead of the phase it covers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      drove_reg <= 1'b0;
    end else begin
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      if (start_go) begin
        // One low clock, then released, never driven high
        oe_reg <= 1'b1;
        out_reg <= 1'b0;
      end else if (state_reg == SIRQ_DS_FRAMES && frame_reg <= SIRQ_FRAME_LAST) begin
        unique case (phase_reg)
          SIRQ_PH_TURN: begin
            // Next clock is a sample phase
            oe_reg <= ~frame_bit(det_reg, frame_reg);
            out_reg <= 1'b0;
            drove_reg <= ~frame_bit(det_reg, frame_reg);
          end
          SIRQ_PH_SAMPLE: begin
            // Next clock is recovery
            oe_reg <= drove_reg;
            out_reg <= 1'b1;
          end
          SIRQ_PH_REC: begin
            oe_reg <= 1'b0;
            drove_reg <= 1'b0;
          end
          default: begin
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Status outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= (state_reg != SIRQ_DS_IDLE);
    end
  end

  assign link.dev_oe = oe_reg;
  assign link.dev_out = out_reg;
  assign quiet_mode = quiet_reg;
  assign cycle_active = active_reg;

endmodule // sirq_dev

// ### logic/sirq_host.sv
// Host controller end of the serial interrupt link
`timescale 1ns/100ps
module sirq_host
  import sirq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link side
  sirq_link_if.host link,
  // Control
  input wire logic start_req,
  input wire logic cont_mode,
  input wire logic [2:0] start_ext_clks,
  // Results
  output logic [16:1] frame_levels,
  output logic cycle_done,
  output logic quiet_mode
);

  sirq_host_state_e state_reg; // Cycle state
  logic line; // Wire level
  logic [2:0] ext_eff; // Start extension, at least the minimum
  logic [3:0] cnt_reg; // Low clocks driven so far
  logic [3:0] tgt_reg; // Low clocks to drive
  logic [1:0] phase_reg; // Position within frame
  logic [4:0] frame_reg; // Upcoming frame index
  logic holdoff_reg; // Idle long enough to start
  logic quiet_reg; // Mode of next cycle
  logic oe_reg; // Drive enable
  logic out_reg; // Drive value
  logic [16:1] lvl_reg; // Sampled frame levels
  logic done_reg; // Cycle finished pulse

  assign line = link.serial_interrupt_line;
  assign ext_eff = (start_ext_clks < SIRQ_EXT_MIN) ? SIRQ_EXT_MIN : start_ext_clks;

  // Cycle sequencing and wire drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= SIRQ_HS_IDLE;
      cnt_reg <= SIRQ_CNT_ONE;
      tgt_reg <= SIRQ_CNT_ONE;
      phase_reg <= SIRQ_PH_REC;
      frame_reg <= SIRQ_FRAME_FIRST;
      holdoff_reg <= 1'b0;
      quiet_reg <= 1'b0;
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        SIRQ_HS_IDLE: begin
          holdoff_reg <= 1'b1;
          if (holdoff_reg && quiet_reg && !line) begin
            // Slave began a start pulse: take over the low drive
            state_reg <= SIRQ_HS_START;
            oe_reg <= 1'b1;
            out_reg <= 1'b0;
            cnt_reg <= SIRQ_CNT_ONE;
            tgt_reg <= {1'b0, ext_eff};
          end else if (holdoff_reg && start_req) begin
            state_reg <= SIRQ_HS_START;
            oe_reg <= 1'b1;
            out_reg <= 1'b0;
            cnt_reg <= SIRQ_CNT_ONE;
            tgt_reg <= {1'b0, ext_eff} + SIRQ_CNT_ONE;
          end
        end
        SIRQ_HS_START: begin
          if (cnt_reg == tgt_reg) begin
            state_reg <= SIRQ_HS_RISE;
            out_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        SIRQ_HS_RISE: begin
          // Rising edge clock; release next
          oe_reg <= 1'b0;
          state_reg <= SIRQ_HS_RUN;
          phase_reg <= SIRQ_PH_TURN;
          frame_reg <= SIRQ_FRAME_FIRST;
        end
        SIRQ_HS_RUN: begin
          if (phase_reg == SIRQ_PH_SAMPLE) begin
            phase_reg <= SIRQ_PH_REC;
            frame_reg <= frame_reg + 5'h01;
          end else begin
            phase_reg <= phase_reg + 2'h1;
          end
          if (phase_reg == SIRQ_PH_TURN && frame_reg == SIRQ_FRAME_END) begin
            // Stop pulse width selects the next mode
            state_reg <= SIRQ_HS_STOP;
            oe_reg <= 1'b1;
            out_reg <= 1'b0;
            cnt_reg <= SIRQ_CNT_ONE;
            tgt_reg <= {2'h0, cont_mode ? SIRQ_STOP_CONT : SIRQ_STOP_QUIET};
            quiet_reg <= !cont_mode;
          end
        end
        SIRQ_HS_STOP: begin
          if (cnt_reg == tgt_reg) begin
            state_reg <= SIRQ_HS_STOP_HI;
            out_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        SIRQ_HS_STOP_HI: begin
          oe_reg <= 1'b0;
          done_reg <= 1'b1;
          holdoff_reg <= 1'b0;
          state_reg <= SIRQ_HS_IDLE;
        end
      endcase
    end
  end

  // Frame level capture in the sample phase of frames one to sixteen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_reg <= '1;
    end else if (state_reg == SIRQ_HS_RUN && phase_reg == SIRQ_PH_SAMPLE) begin
      for (int k = 1; k <= SIRQ_NUM_FRAMES; k++) begin
        if (frame_reg == 5'(k)) begin
          lvl_reg[k] <= line;
        end
      end
    end
  end

  assign link.host_oe = oe_reg;
  assign link.host_out = out_reg;
  assign frame_levels = lvl_reg;
  assign cycle_done = done_reg;
  assign quiet_mode = quiet_reg;

endmodule // sirq_host

// ### tb/sirq_link_asserts.sv
// Concurrent checks on the serial interrupt wire between both ends
`timescale 1ns/100ps
module sirq_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wire drivers and resolved level
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic host_oe,
  input wire logic host_out,
  input wire logic serial_interrupt_line
);
  logic [3:0] low_cnt_reg; // Consecutive low clocks seen
  logic [5:0] cyc_reg; // Clocks since start pulse rose, saturating
  logic quiet_reg; // Mode taken from the last stop width
  logic dev_low; // Device pulls the wire low
  logic host_low; // Host pulls the wire low
  logic in_frames; // Inside the frame window, ending before the stop pulse
  logic start_rise; // First high clock after a start pulse
  assign dev_low = dev_oe && !dev_out;
  assign host_low = host_oe && !host_out;
  assign in_frames = (cyc_reg != 6'h00) && (cyc_reg <= 6'h34);
  assign start_rise = serial_interrupt_line && (low_cnt_reg >= 4'h4);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Count the length of each low run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 4'h0;
    end else if (serial_interrupt_line) begin
      low_cnt_reg <= 4'h0;
    end else if (low_cnt_reg != 4'hF) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  // Position inside the cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_reg <= 6'h00;
    end else if (start_rise) begin
      cyc_reg <= 6'h01;
    end else if (cyc_reg != 6'h00 && cyc_reg != 6'h3F) begin
      cyc_reg <= cyc_reg + 6'h01;
    end
  end

  // Mode decoded from stop width, continuous after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 1'b0;
    end else if (serial_interrupt_line && cyc_reg > 6'h2F && low_cnt_reg == 4'h2) begin
      quiet_reg <= 1'b1;
    end else if (serial_interrupt_line && cyc_reg > 6'h2F && low_cnt_reg == 4'h3) begin
      quiet_reg <= 1'b0;
    end
  end

  a_reset_release: assert property (disable iff (1'b0) rst |-> !dev_oe && !host_oe)
    else $error("wire driven during reset");
  a_sample_slot: assert property (dev_low && in_frames |->
    cyc_reg >= 6'h05 && cyc_reg <= 6'h2F && cyc_reg % 6'h03 == 6'h02)
    else $error("device low outside a sample clock");
  a_low_single: assert property (dev_low |=> !dev_low)
    else $error("device low for two clocks");
  a_recover_high: assert property (dev_low && in_frames |=> dev_oe && dev_out)
    else $error("no recovery drive after sample");
  a_high_needs_low: assert property (dev_oe && dev_out |-> $past(dev_low))
    else $error("device drove high without prior low");
  a_turn_release: assert property (dev_oe && dev_out |=> !dev_oe)
    else $error("device not released in turnaround");
  a_quiet_release: assert property (dev_low && !in_frames |=> !dev_oe)
    else $error("start clock not followed by release");
  a_start_gate: assert property (dev_low && !in_frames |->
    quiet_reg && cyc_reg >= 6'h39)
    else $error("device start not allowed here");
  a_host_takeover: assert property (dev_low && !in_frames |=> host_low [*3])
    else $error("host did not extend device start");
  a_start_width: assert property (start_rise |-> low_cnt_reg <= 4'h8)
    else $error("start pulse longer than eight clocks");
  a_stop_place: assert property (serial_interrupt_line && low_cnt_reg inside {4'h2, 4'h3} |->
    cyc_reg == 6'h37 || cyc_reg == 6'h38)
    else $error("stop pulse misplaced or wrong width");
  a_host_quiet_frames: assert property (host_low |-> !in_frames)
    else $error("host low inside the frames");

  c_dev_start: cover property (dev_low && !in_frames);
  c_cont_stop: cover property (serial_interrupt_line && low_cnt_reg == 4'h3);
  c_back_to_back: cover property (start_rise && cyc_reg > 6'h38 && cyc_reg < 6'h3F);
endmodule // sirq_link_asserts

// ### tb/tb_serial_irq_slave_agent.sv
// Self-checking bench joining the device end and the host end
`timescale 1ns/100ps
module tb_serial_irq_slave_agent;
  import sirq_pkg::*;
  // Table row: inputs beside expected host levels
  typedef struct packed {
    logic [15:1] irq;
    logic smi_n;
    logic en;
    logic [2:0] ext;
    logic [16:1] exp;
  } sirq_row_s;
  localparam sirq_row_s ROWS [7] = '{
    '{15'h7FFF, 1'b1, 1'b1, 3'h3, 16'hFFFF},
    '{15'h7FFE, 1'b1, 1'b1, 3'h7, 16'hFFFD},
    '{15'h7FFF, 1'b0, 1'b1, 3'h4, 16'hFFFB},
    '{15'h7FFF, 1'b0, 1'b0, 3'h5, 16'hFFFF},
    '{15'h5555, 1'b1, 1'b1, 3'h6, 16'hAAAB},
    '{15'h2AAA, 1'b1, 1'b1, 3'h3, 16'h5555},
    '{15'h0000, 1'b0, 1'b1, 3'h7, 16'h0001}};
  logic mclk = 1'b0; // Bus clock
  logic rst = 1'b0; // Link reset, raised at the first falling edge
  logic [15:1] irq = 15'h7FFF; // Request levels, low asserts
  logic smi_n = 1'b1; // Management request, active low
  logic smi_en = 1'b1; // Management request let onto frame three
  logic start_req = 1'b0; // Host start request
  logic cont = 1'b1; // Host stop width choice
  logic [2:0] ext = 3'h3; // Host start extension
  logic [16:1] levels; // Levels seen by the host
  logic done; // Host cycle finished
  logic hq; // Host mode
  logic dq; // Device mode
  logic act; // Device busy
  int n_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int n_done = 0; // Finished host cycles
  sirq_link_if link ();
  sirq_dev sirq_dev_inst (.mclk(mclk), .rst(rst), .link(link), .irq_level_in(irq),
    .system_mgmt_request_n(smi_n), .mgmt_request_enable_mask(smi_en),
    .quiet_mode(dq), .cycle_active(act));
  sirq_host sirq_host_inst (.mclk(mclk), .rst(rst), .link(link), .start_req(start_req),
    .cont_mode(cont), .start_ext_clks(ext), .frame_levels(levels), .cycle_done(done),
    .quiet_mode(hq));
  sirq_link_asserts sirq_link_asserts_inst (.mclk(mclk), .rst(rst), .dev_oe(link.dev_oe),
    .dev_out(link.dev_out), .host_oe(link.host_oe), .host_out(link.host_out),
    .serial_interrupt_line(link.serial_interrupt_line));

  // Clock and cycle counter
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (done === 1'b1) n_done++;

  // Compare host levels
  task automatic chk16(input logic [16:1] got, input logic [16:1] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare one bit
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Report and end the run
  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bounded wait for the host to finish a cycle
  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (done === 1'b1) return;
    end
    chk1(1'b0, 1'b1);
    close_out();
  endtask

  // Host started cycle, request dropped once the wire goes low
  task automatic run_cycle;
    int i;
    start_req = 1'b1;
    for (i = 0; i < 20 && link.serial_interrupt_line !== 1'b0; i++) @(negedge mclk);
    start_req = 1'b0;
    // Device joins the cycle even though the host began it
    repeat (2) @(negedge mclk);
    chk1(act, 1'b1);
    wait_done(100);
  endtask

  // Main sequence
  initial begin
    int k;
    // Raised on a falling edge so every register is reset before checks start
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk1(link.dev_oe, 1'b0);
    chk1(link.serial_interrupt_line, 1'b1);
    chk1(dq, 1'b0);
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      irq = ROWS[i].irq;
      smi_n = ROWS[i].smi_n;
      smi_en = ROWS[i].en;
      ext = ROWS[i].ext;
      repeat (4) @(negedge mclk);
      run_cycle();
      chk16(levels, ROWS[i].exp);
      chk1(dq, 1'b0);
    end
    // Quiet mode: device starts on a level change
    irq = 15'h7FFF;
    smi_n = 1'b1;
    repeat (4) @(negedge mclk);
    cont = 1'b0;
    run_cycle();
    chk1(dq, 1'b1);
    chk1(hq, 1'b1);
    irq = 15'h7FEF;
    wait_done(200);
    chk16(levels, 16'hFFDF);
    // Release of the request also starts, stop switches to continuous
    cont = 1'b1;
    irq = 15'h7FFF;
    wait_done(200);
    chk16(levels, 16'hFFFF);
    chk1(dq, 1'b0);
    // Continuous: device stays passive
    irq = 15'h7FFE;
    // Let the last done pulse be counted before taking the reference
    @(negedge mclk);
    k = n_done;
    repeat (150) @(negedge mclk);
    chk1(n_done == k, 1'b1);
    chk1(act, 1'b0);
    run_cycle();
    chk16(levels, 16'hFFFD);
    // Host cycles back to back, change lands in the second one
    start_req = 1'b1;
    wait_done(100);
    irq = 15'h3FFF;
    wait_done(120);
    start_req = 1'b0;
    chk16(levels, 16'h7FFF);
    repeat (80) @(negedge mclk);
    // Reset inside a device started cycle
    cont = 1'b0;
    run_cycle();
    chk1(dq, 1'b1);
    irq = 15'h7FFE;
    repeat (20) @(negedge mclk);
    chk1(act, 1'b1);
    rst = 1'b1;
    @(negedge mclk);
    chk1(link.serial_interrupt_line, 1'b1);
    chk1(dq, 1'b0);
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    // Pending change must wait for a host start after reset
    repeat (150) @(negedge mclk);
    chk1(act, 1'b0);
    run_cycle();
    chk16(levels, 16'hFFFD);
    close_out();
  end
endmodule // tb_serial_irq_slave_agent
